// file: common/mss_pkg.sv
// constants, encodings and types for the measurement sequence scheduler
// Behaviour
// - in step-response mode at most 6 auxiliary slots follow a normal/inverted pair and at most 7 follow a lone normal sample.
// - single-sequence execution is reserved and is refused as a configuration error.
// - in continuous cyclic execution the sequence repeats endlessly, wrapping from the last slot to the first.
// - execution triggered by another front end is reserved and is refused as a configuration error.
// - only in continuous cyclic execution an idle gap of up to 10 ms is inserted between sequences.
// - accelerated mode offers normal plus inverted, normal with auto-zero auxiliary, or normal only as baseline.
// - normal samples only without the auto-zero auxiliary means no internal offset compensation.
// - with advanced options, accelerated mode inserts one auxiliary slot after 2, 4 or 8 measurements of 4 pairs.
// - with normal-only baselines the auxiliary slot follows 16/32/64 normal samples, plus a zero-offset sample if chosen.
// - normal plus inverted at rate two gives eight inverted and eight normal samples, then one auxiliary slot.
// - accelerated mode skips settling waits and reports one bit less effective resolution.
// - the auxiliary-only mode works on one chosen front end and only with advanced options on.
package mss_pkg;

  localparam int CLK_PERIOD_PS      = 4000;
  localparam int CYC_PER_US         = 1000000 / CLK_PERIOD_PS;
  localparam int IDLE_MAX_MS        = 10;
  localparam int IDLE_MAX_US        = IDLE_MAX_MS * 1000;
  localparam int IDLE_W             = 14;
  localparam int STEP_MAX_AUX_PAIR  = 6;
  localparam int STEP_MAX_AUX_ONE   = 7;
  localparam int PAIRS_PER_MEAS     = 4;
  localparam int SAMP_PER_MEAS      = 2 * PAIRS_PER_MEAS;
  localparam int PRE_W              = 12;

  // gray along idle -> run -> gap
  typedef enum logic [1:0] {
    MSS_ST_IDLE = 2'h0,
    MSS_ST_RUN  = 2'h1,
    MSS_ST_GAP  = 2'h3,
    MSS_ST_HALT = 2'h2
  } mss_state_e;

  typedef enum logic [1:0] {
    MAIN_STEP     = 2'h0,
    MAIN_ACCEL    = 2'h1,
    MAIN_AUX_ONLY = 2'h2
  } mss_main_e;

  typedef enum logic [1:0] {
    EXEC_SINGLE = 2'h0,
    EXEC_CONT   = 2'h1,
    EXEC_TRIG   = 2'h2
  } mss_exec_e;

  typedef enum logic [1:0] {
    STEP_POS_NEG_AUX = 2'h0,
    STEP_NEG_POS_AUX = 2'h1,
    STEP_POS_AUX     = 2'h2
  } mss_stepc_e;

  typedef enum logic [1:0] {
    ACC_POS_NEG       = 2'h0,
    ACC_AUTO_ZERO_AUX = 2'h1,
    ACC_POS_ONLY      = 2'h2
  } mss_accc_e;

  typedef enum logic [1:0] {
    RATE_2 = 2'h0,
    RATE_4 = 2'h1,
    RATE_8 = 2'h2
  } mss_rate_e;

  typedef enum logic [2:0] {
    SLOT_NONE            = 3'h0,
    SLOT_NORMAL_SAMPLE   = 3'h1,
    SLOT_INVERTED_SAMPLE = 3'h2,
    SLOT_AUX             = 3'h3,
    SLOT_ZERO_OFFSET     = 3'h4
  } mss_slot_e;

  // one sequence as derived from the settings
  typedef struct packed {
    logic       ok;
    logic [6:0] n_samp;
    logic       alt;
    logic       first_inv;
    logic [2:0] n_aux;
    logic       zero_extra;
    logic       comp;
    logic       accel;
    logic       settle;
  } mss_plan_s;

endpackage

// file: common/mss_gap_if.sv
// idle gap request and completion between scheduler and gap timer
`timescale 1ns/1ps
`default_nettype none
interface mss_gap_if;
  logic                         start;
  logic [mss_pkg::IDLE_W-1:0]   len_us;
  logic                         done;

  modport sched (output start, output len_us, input done);
  modport timer (input start, input len_us, output done);
endinterface
`default_nettype wire

// file: rtl/mss_gap_timer.sv
// microsecond idle gap timer
`timescale 1ns/1ps
`default_nettype none
module mss_gap_timer #(
  parameter int CYC_PER_US = mss_pkg::CYC_PER_US
) (
  input  wire logic   core_clk,
  input  wire logic   rstn,
  mss_gap_if.timer    gap
);

  if (CYC_PER_US < 1 || CYC_PER_US > (1 << mss_pkg::PRE_W))
  begin : g_chk
    $error("gap timer prescale out of range");
  end

  typedef struct packed {
    logic                         busy;
    logic [mss_pkg::PRE_W-1:0]    pre;
    logic [mss_pkg::IDLE_W-1:0]   us;
    logic                         done;
  } mss_tmr_s;

  mss_tmr_s t_q;
  mss_tmr_s t_d;

  // prescale to microseconds, then count down the gap
  always_comb
  begin
    t_d      = t_q;
    t_d.done = 1'b0;
    if (gap.start && gap.len_us != '0)
    begin
      t_d.busy = 1'b1;
      t_d.pre  = '0;
      t_d.us   = gap.len_us;
    end
    else if (t_q.busy)
    begin
      if (t_q.pre == mss_pkg::PRE_W'(CYC_PER_US - 1))
      begin
        t_d.pre = '0;
        if (t_q.us == mss_pkg::IDLE_W'(1))
        begin
          t_d.busy = 1'b0;
          t_d.done = 1'b1;
        end
        else
          t_d.us = t_q.us - mss_pkg::IDLE_W'(1);
      end
      else
        t_d.pre = t_q.pre + mss_pkg::PRE_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign gap.done = t_q.done;

endmodule
`default_nettype wire

// file: rtl/mss_top.sv
// measurement slot scheduler for one converter front end
`timescale 1ns/1ps
`default_nettype none
module mss_top #(
  parameter int   CYC_PER_US  = mss_pkg::CYC_PER_US,
  parameter logic AUX_ONLY_FE = 1'b0
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        seq_enable,
  input  wire logic                        front_end_sel,
  input  wire logic [1:0]                  main_mode,
  input  wire logic                        advanced_en,
  input  wire logic [1:0]                  exec_mode,
  input  wire logic [1:0]                  step_comb,
  input  wire logic [2:0]                  aux_count,
  input  wire logic [1:0]                  accel_comb,
  input  wire logic [1:0]                  insert_rate,
  input  wire logic [mss_pkg::IDLE_W-1:0]  idle_time_us,
  input  wire logic                        slot_done,
  output var  logic                        slot_valid,
  output var  logic [2:0]                  slot_kind,
  output var  logic                        slot_last,
  output var  logic                        offset_comp_en,
  output var  logic                        reduced_resolution,
  output var  logic                        settle_wait,
  output var  logic                        config_error
);

  if (CYC_PER_US < 1)
  begin : g_chk
    $error("prescale must be at least one cycle");
  end

  typedef struct packed {
    mss_pkg::mss_state_e          st;
    mss_pkg::mss_plan_s           plan;
    logic [mss_pkg::IDLE_W-1:0]   idle;
    logic                         tail;
    logic [6:0]                   pos;
    logic                         valid;
    mss_pkg::mss_slot_e           kind;
    logic                         last;
    logic                         err;
    logic                         gap_go;
  } mss_top_s;

  mss_top_s           s_q;
  mss_top_s           s_d;
  mss_pkg::mss_plan_s plan_now;

  mss_gap_if gap_bus ();

  // derive a sequence plan from the live settings
  function automatic mss_pkg::mss_plan_s plan_f(
    input logic [1:0] mm,
    input logic       adv,
    input logic       fe,
    input logic [1:0] sc,
    input logic [2:0] na,
    input logic [1:0] ac,
    input logic [1:0] rt
  );
    mss_pkg::mss_plan_s p;
    logic [2:0]         lim;
    logic [3:0]         meas;
    p    = '0;
    lim  = 3'(mss_pkg::STEP_MAX_AUX_PAIR);
    meas = 4'h1;
    case (mm)
      mss_pkg::MAIN_STEP:
      begin
        p.ok        = (sc != 2'h3);
        p.alt       = (sc != mss_pkg::STEP_POS_AUX);
        p.first_inv = (sc == mss_pkg::STEP_NEG_POS_AUX);
        p.n_samp    = p.alt ? 7'h02 : 7'h01;
        p.comp      = p.alt;
        p.settle    = 1'b1;
        lim = p.alt ? 3'(mss_pkg::STEP_MAX_AUX_PAIR) : 3'(mss_pkg::STEP_MAX_AUX_ONE);
        // aux count above the limit is clamped rather than refused
        if (!adv || na == 3'h0)
          p.n_aux = 3'h1;
        else
          p.n_aux = (na > lim) ? lim : na;
      end
      mss_pkg::MAIN_ACCEL:
      begin
        case (rt)
          mss_pkg::RATE_2: meas = 4'h2;
          mss_pkg::RATE_4: meas = 4'h4;
          default:         meas = 4'h8;
        endcase
        if (!adv)
          meas = 4'h1;
        p.ok         = (ac != 2'h3) && (!adv || rt != 2'h3);
        p.accel      = 1'b1;
        // widen before the product: 8 measurements give 64 samples, beyond 4 bits
        p.n_samp     = 7'(meas) * 7'(mss_pkg::SAMP_PER_MEAS);
        p.alt        = (ac == mss_pkg::ACC_POS_NEG);
        p.comp       = (ac != mss_pkg::ACC_POS_ONLY);
        p.zero_extra = (ac == mss_pkg::ACC_AUTO_ZERO_AUX);
        p.n_aux      = (adv || p.zero_extra) ? 3'h1 : 3'h0;
      end
      mss_pkg::MAIN_AUX_ONLY:
      begin
        p.ok    = adv && (fe == AUX_ONLY_FE);
        p.n_aux = 3'h1;
      end
      default:
        p.ok = 1'b0;
    endcase
    return p;
  endfunction

  // slots after the samples: aux slots plus optional zero-offset sample
  function automatic logic [3:0] tail_f(input mss_pkg::mss_plan_s p);
    return {1'b0, p.n_aux} + {3'h0, p.zero_extra};
  endfunction

  function automatic mss_pkg::mss_slot_e kind_f(
    input mss_pkg::mss_plan_s p,
    input logic               tail,
    input logic [6:0]         pos
  );
    if (tail)
      return (p.zero_extra && pos[2:0] == p.n_aux) ? mss_pkg::SLOT_ZERO_OFFSET : mss_pkg::SLOT_AUX;
    if (p.alt && (pos[0] ^ p.first_inv))
      return mss_pkg::SLOT_INVERTED_SAMPLE;
    return mss_pkg::SLOT_NORMAL_SAMPLE;
  endfunction

  function automatic logic last_f(
    input mss_pkg::mss_plan_s p,
    input logic               tail,
    input logic [6:0]         pos
  );
    if (tail)
      return pos == {3'h0, tail_f(p) - 4'h1};
    return (pos == p.n_samp - 7'h01) && (tail_f(p) == 4'h0);
  endfunction

  // sequence boundary: settings are sampled only here
  function automatic mss_top_s start_f(
    input mss_top_s                    s,
    input logic                        en,
    input logic [1:0]                  ex,
    input mss_pkg::mss_plan_s          p,
    input logic [mss_pkg::IDLE_W-1:0]  idl
  );
    mss_top_s n;
    n        = s;
    n.valid  = 1'b0;
    n.last   = 1'b0;
    n.tail   = 1'b0;
    n.pos    = 7'h00;
    n.gap_go = 1'b0;
    n.err    = 1'b0;
    n.kind   = mss_pkg::SLOT_NONE;
    if (!en)
    begin
      n.st   = mss_pkg::MSS_ST_IDLE;
      n.plan = '0;
    end
    else if (!p.ok || ex != mss_pkg::EXEC_CONT)
    begin
      n.st   = mss_pkg::MSS_ST_HALT;
      n.err  = 1'b1;
      n.plan = '0;
    end
    else
    begin
      n.st    = mss_pkg::MSS_ST_RUN;
      n.plan  = p;
      n.idle  = (idl > mss_pkg::IDLE_W'(mss_pkg::IDLE_MAX_US)) ? mss_pkg::IDLE_W'(mss_pkg::IDLE_MAX_US) : idl;
      n.tail  = (p.n_samp == 7'h00);
      n.valid = 1'b1;
      n.kind  = kind_f(p, n.tail, 7'h00);
      n.last  = last_f(p, n.tail, 7'h00);
    end
    return n;
  endfunction

  assign plan_now = plan_f(main_mode, advanced_en, front_end_sel, step_comb, aux_count, accel_comb, insert_rate);

  // slot stepping; one slot per front end completion
  always_comb
  begin
    s_d        = s_q;
    s_d.gap_go = 1'b0;
    case (s_q.st)
      mss_pkg::MSS_ST_IDLE,
      mss_pkg::MSS_ST_HALT:
        s_d = start_f(s_q, seq_enable, exec_mode, plan_now, idle_time_us);
      mss_pkg::MSS_ST_RUN:
      begin
        if (slot_done && s_q.valid)
        begin
          if (s_q.last)
          begin
            // gap only exists in cyclic mode, the only one that runs
            if (s_q.idle != '0)
            begin
              s_d.st     = mss_pkg::MSS_ST_GAP;
              s_d.valid  = 1'b0;
              s_d.last   = 1'b0;
              s_d.kind   = mss_pkg::SLOT_NONE;
              s_d.gap_go = 1'b1;
            end
            else
              s_d = start_f(s_q, seq_enable, exec_mode, plan_now, idle_time_us);
          end
          else
          begin
            if (!s_q.tail && s_q.pos == s_q.plan.n_samp - 7'h01)
            begin
              s_d.tail = 1'b1;
              s_d.pos  = 7'h00;
            end
            else
              s_d.pos = s_q.pos + 7'h01;
            s_d.kind = kind_f(s_q.plan, s_d.tail, s_d.pos);
            s_d.last = last_f(s_q.plan, s_d.tail, s_d.pos);
          end
        end
      end
      mss_pkg::MSS_ST_GAP:
      begin
        if (gap_bus.done)
          s_d = start_f(s_q, seq_enable, exec_mode, plan_now, idle_time_us);
      end
      default:
        s_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign gap_bus.start  = s_q.gap_go;
  assign gap_bus.len_us = s_q.idle;

  mss_gap_timer #(
    .CYC_PER_US (CYC_PER_US)
  ) u_gap (
    .core_clk (core_clk),
    .rstn     (rstn),
    .gap      (gap_bus.timer)
  );

  // all outputs straight from the state register
  assign slot_valid         = s_q.valid;
  assign slot_kind          = s_q.kind;
  assign slot_last          = s_q.last;
  assign offset_comp_en     = s_q.plan.comp;
  assign reduced_resolution = s_q.plan.accel;
  assign settle_wait        = s_q.plan.settle;
  assign config_error       = s_q.err;

endmodule
`default_nettype wire

// file: test/mss_top_monitor.sv
// port checker for the measurement slot scheduler
`timescale 1ns/1ps
`default_nettype none
module mss_top_monitor #(
  parameter logic AUX_ONLY_FE = 1'b0
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       front_end_sel,
  input wire logic [1:0] main_mode,
  input wire logic       advanced_en,
  input wire logic [1:0] exec_mode,
  input wire logic [1:0] insert_rate,
  input wire logic       slot_done,
  input wire logic       slot_valid,
  input wire logic [2:0] slot_kind,
  input wire logic       slot_last,
  input wire logic       offset_comp_en,
  input wire logic       reduced_resolution,
  input wire logic       settle_wait,
  input wire logic       config_error
);
  logic       take;
  logic [3:0] aux_run_q;
  logic [7:0] samp_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  assign take = slot_valid && slot_done;

  // run of taken aux slots and samples since the last aux or sequence end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aux_run_q <= 4'h0;
      samp_q    <= 8'h00;
    end
    else if (take)
    begin
      aux_run_q <= (slot_kind == mss_pkg::SLOT_AUX) ? aux_run_q + 4'h1 : 4'h0;
      samp_q    <= (slot_kind == mss_pkg::SLOT_AUX || slot_last) ? 8'h00 :
                   (slot_kind == 3'h1 || slot_kind == 3'h2) ? samp_q + 8'h01 : samp_q;
    end
  end

  AST_ERR_NO_SLOT: assert property (config_error |-> !slot_valid)
    else $error("slot offered while settings refused");
  AST_START_EXEC: assert property ($rose(slot_valid) |-> $past(exec_mode) == mss_pkg::EXEC_CONT)
    else $error("sequence started outside cyclic execution");
  AST_AUX_ONLY_GATE:
    assert property ($rose(slot_valid) && $past(main_mode) == mss_pkg::MAIN_AUX_ONLY
      |-> $past(advanced_en) && $past(front_end_sel) == AUX_ONLY_FE)
    else $error("aux-only run without advanced options or on wrong front end");
  AST_SLOT_HOLD: assert property (slot_valid && !slot_done |=> slot_valid && $stable(slot_kind) && $stable(slot_last))
    else $error("slot changed before it was finished");
  AST_PLAN_HOLD:
    assert property (take && !slot_last |=> $stable(offset_comp_en) && $stable(reduced_resolution) && $stable(settle_wait))
    else $error("plan outputs changed inside a sequence");
  AST_STEP_AUX_MAX:
    assert property (take && settle_wait && main_mode == mss_pkg::MAIN_STEP && slot_kind == mss_pkg::SLOT_AUX
      |-> aux_run_q < 4'h7)
    else $error("more than seven aux slots in step mode");
  AST_ACCEL_RATE:
    assert property (take && slot_kind == mss_pkg::SLOT_AUX && reduced_resolution && advanced_en && insert_rate < 2'h3
      |-> samp_q == (8'h10 << insert_rate))
    else $error("aux slot not after the selected number of samples");
  AST_MODE_EXCL: assert property (slot_valid |-> !(reduced_resolution && settle_wait))
    else $error("accelerated and settling flags both set");
  AST_ZERO_COMP: assert property (take && slot_kind == mss_pkg::SLOT_ZERO_OFFSET |-> offset_comp_en && slot_last)
    else $error("zero-offset slot misplaced or uncompensated");
  AST_INV_COMP:
    assert property (slot_valid && reduced_resolution && slot_kind == mss_pkg::SLOT_INVERTED_SAMPLE |-> offset_comp_en)
    else $error("inverted sample without compensation");

  // main scenarios reached
  cover property (take && slot_kind == mss_pkg::SLOT_ZERO_OFFSET);
  cover property ($rose(config_error));
  cover property (take && slot_last ##1 !slot_valid);
endmodule

bind mss_top mss_top_monitor #(.AUX_ONLY_FE(AUX_ONLY_FE)) i_mss_top_monitor (
  .core_clk, .rstn, .front_end_sel, .main_mode, .advanced_en, .exec_mode, .insert_rate, .slot_done,
  .slot_valid, .slot_kind, .slot_last, .offset_comp_en, .reduced_resolution, .settle_wait, .config_error
);
`default_nettype wire

// file: test/mss_fe_model.sv
// converter front end model that finishes scheduled slots
`timescale 1ns/1ps
`default_nettype none
module mss_fe_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       slot_valid,
  input  wire logic [3:0] lag,
  output var  logic       slot_done = 1'b0
);
  int cnt;

  // answers after lag cycles; lag 0 keeps done high for back to back slots
  always @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt = 0;
      slot_done <= 1'b0;
    end
    else if (slot_valid && cnt >= lag)
    begin
      cnt = 0;
      slot_done <= 1'b1;
    end
    else
    begin
      cnt = slot_valid ? cnt + 1 : 0;
      slot_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: test/mss_top_test.sv
// self-checking bench for the measurement slot scheduler
`timescale 1ns/1ps
`default_nettype none
module mss_top_test;
  logic                       core_clk = 1'b0;
  logic                       rstn = 1'b0;
  logic                       seq_enable;
  logic                       front_end_sel;
  logic [1:0]                 main_mode;
  logic                       advanced_en;
  logic [1:0]                 exec_mode;
  logic [1:0]                 step_comb;
  logic [2:0]                 aux_count;
  logic [1:0]                 accel_comb;
  logic [1:0]                 insert_rate;
  logic [mss_pkg::IDLE_W-1:0] idle_time_us;
  logic [3:0]                 lag;
  logic                       slot_done;
  logic                       slot_valid;
  logic [2:0]                 slot_kind;
  logic                       slot_last;
  logic                       offset_comp_en;
  logic                       reduced_resolution;
  logic                       settle_wait;
  logic                       config_error;
  logic [3:0]                 log_q[$];
  logic [3:0]                 exp_q[$];
  int                         err_total = 0;
  int                         n_checks = 0;

  // 4 ns clock
  always #2 core_clk = ~core_clk;

  // gap timer shortened to 2 cycles per microsecond
  mss_top #(.CYC_PER_US(2), .AUX_ONLY_FE(1'b1)) i_mss_top (
    .core_clk, .rstn, .seq_enable, .front_end_sel, .main_mode, .advanced_en, .exec_mode, .step_comb,
    .aux_count, .accel_comb, .insert_rate, .idle_time_us, .slot_done, .slot_valid, .slot_kind,
    .slot_last, .offset_comp_en, .reduced_resolution, .settle_wait, .config_error
  );
  mss_fe_model i_mss_fe_model (.core_clk, .rstn, .slot_valid, .lag, .slot_done);

  // record each finished slot as {last, kind}
  always @(posedge core_clk)
  begin
    if (rstn && slot_valid && slot_done)
      log_q.push_back({slot_last, slot_kind});
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic grab(input int n);
    for (int i = 0; i < 4000 && log_q.size() < n; i++)
      @(negedge core_clk);
    chk(log_q.size() >= n, 1);
  endtask

  // disable applies at the boundary, so wait for a quiet stretch
  task automatic halt_seq();
    int q;
    @(negedge core_clk);
    seq_enable = 1'b0;
    q = 0;
    for (int i = 0; i < 4000 && q < 8; i++)
    begin
      @(negedge core_clk);
      q = slot_valid ? 0 : q + 1;
    end
    log_q.delete();
  endtask

  // one sequence plus the first slot after the wrap
  task automatic seq_case(input logic [1:0] mm, input logic [1:0] cb, input logic adv, input logic [2:0] nr);
    int m;
    exp_q.delete();
    main_mode = mm;
    step_comb = cb;
    accel_comb = cb;
    advanced_en = adv;
    aux_count = nr;
    insert_rate = nr[1:0];
    if (mm == mss_pkg::MAIN_STEP)
    begin
      if (cb != 2'h1)
        exp_q.push_back(4'h1);
      if (cb != 2'h2)
        exp_q.push_back(4'h2);
      if (cb == 2'h1)
        exp_q.push_back(4'h1);
      m = (!adv || nr == 3'h0) ? 1 : int'(nr);
      if (m > 6 + (cb == 2'h2))
        m = 6 + (cb == 2'h2);
      repeat (m)
        exp_q.push_back(4'h3);
    end
    else
    begin
      m = adv ? 16 << nr : 8;
      for (int i = 0; i < m; i++)
        exp_q.push_back((cb == 2'h0 && i % 2 == 1) ? 4'h2 : 4'h1);
      if (adv || cb == 2'h1)
        exp_q.push_back(4'h3);
      if (cb == 2'h1)
        exp_q.push_back(4'h4);
    end
    exp_q[$] = exp_q[$] | 4'h8;
    seq_enable = 1'b1;
    grab(exp_q.size() + 1);
    foreach (exp_q[i])
      chk(log_q[i], exp_q[i]);
    chk(log_q[exp_q.size()], exp_q[0]);
    chk({reduced_resolution, settle_wait}, {mm == mss_pkg::MAIN_ACCEL, mm == mss_pkg::MAIN_STEP});
    if (mm == mss_pkg::MAIN_ACCEL)
      chk(offset_comp_en, cb != 2'h2);
    halt_seq();
  endtask

  task automatic t_step();
    lag = 4'h2;
    for (int c = 0; c < 3; c++)
    begin
      seq_case(mss_pkg::MAIN_STEP, 2'(c), 1'b0, 3'h0);
      seq_case(mss_pkg::MAIN_STEP, 2'(c), 1'b1, 3'h7);
      seq_case(mss_pkg::MAIN_STEP, 2'(c), 1'b1, 3'h3);
    end
    $display("test step done");
  endtask

  task automatic t_accel();
    lag = 4'h0;
    for (int c = 0; c < 3; c++)
    begin
      seq_case(mss_pkg::MAIN_ACCEL, 2'(c), 1'b0, 3'h0);
      for (int r = 0; r < 3; r++)
        seq_case(mss_pkg::MAIN_ACCEL, 2'(c), 1'b1, 3'(r));
    end
    $display("test accel done");
  endtask

  // new combination waits for the sequence boundary
  task automatic t_change();
    lag = 4'h1;
    main_mode = mss_pkg::MAIN_STEP;
    step_comb = 2'h0;
    advanced_en = 1'b0;
    seq_enable = 1'b1;
    grab(1);
    step_comb = 2'h2;
    grab(5);
    chk({log_q[0], log_q[1], log_q[2], log_q[3], log_q[4]}, 20'h12B1B);
    halt_seq();
    $display("test change done");
  endtask

  task automatic t_error();
    lag = 4'h0;
    seq_enable = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      exec_mode = 2'(e);
      repeat (8) @(negedge core_clk);
      chk({config_error, slot_valid}, {e != 1, e == 1});
    end
    // undefined mode, combination and rate codes are all refused
    exec_mode = 2'h1;
    advanced_en = 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      main_mode = (v == 0) ? 2'h3 : ((v == 1) ? 2'h0 : 2'h1);
      step_comb = 2'h3;
      accel_comb = (v == 3) ? 2'h0 : 2'h3;
      insert_rate = (v == 3) ? 2'h3 : 2'h0;
      repeat (8) @(negedge core_clk);
      chk({config_error, slot_valid}, 2'h2);
    end
    main_mode = mss_pkg::MAIN_AUX_ONLY;
    exec_mode = 2'h1;
    for (int k = 0; k < 3; k++)
    begin
      advanced_en = k > 0;
      front_end_sel = k == 2;
      repeat (8) @(negedge core_clk);
      chk({config_error, slot_valid}, {k != 2, k == 2});
    end
    chk(log_q[$] & 4'h7, 4'h3);
    rstn = 1'b0;
    #1;
    chk({slot_valid, config_error, slot_kind}, 5'h00);
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    halt_seq();
    $display("test error done");
  endtask

  // gap of 5 us and a clamped maximum, at 2 cycles per microsecond
  task automatic t_idle();
    int n;
    lag = 4'h0;
    main_mode = mss_pkg::MAIN_ACCEL;
    accel_comb = 2'h2;
    advanced_en = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      idle_time_us = (k == 1) ? 14'h3FFF : 14'h0005;
      seq_enable = 1'b1;
      grab(8);
      n = 0;
      while (!slot_valid && n < 30000)
      begin
        @(negedge core_clk);
        n++;
      end
      chk(n >= (k ? 20000 : 10) && n <= (k ? 20006 : 16), 1);
      halt_seq();
    end
    $display("test idle done");
  endtask

  // main sequence
  initial
  begin
    seq_enable = 1'b0;
    front_end_sel = 1'b0;
    main_mode = 2'h0;
    advanced_en = 1'b0;
    exec_mode = 2'h1;
    step_comb = 2'h0;
    aux_count = 3'h0;
    accel_comb = 2'h0;
    insert_rate = 2'h0;
    idle_time_us = 14'h0000;
    lag = 4'h0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    t_step();
    t_accel();
    t_change();
    t_error();
    t_idle();
    conclude();
  end

  // watchdog well past the expected run length
  initial
  begin
    #300000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
